// *** out_drv_regs.sv ***
// page-1 output driver power, common-mode and short-circuit register bank on AXI4-Lite
`include "out_drv_map.svh"
module out_drv_regs
  import out_drv_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   RESET,
  input  wire logic [7:0]             S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  output out_drv_pkg::axi_resp_e      S_AXI_BRESP,
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  input  wire logic [7:0]             S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  output logic [31:0]                 S_AXI_RDATA,
  output out_drv_pkg::axi_resp_e      S_AXI_RRESP,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY,
  input  wire logic                   HP_SHORT_DETECT,
  input  wire logic                   SPK_SHORT_DETECT,
  input  wire logic                   HP_SC_PROTECT_EN,
  output logic                        HEADPHONE_LEFT_DRIVER,
  output logic                        HEADPHONE_RIGHT_DRIVER,
  output out_drv_pkg::cm_level_t      HP_COMMON_MODE,
  output logic                        HP_SC_POWER_DOWN,
  output logic                        HP_SC_LIMIT_CURRENT,
  output logic                        SPEAKER_LEFT_POWER_BIT,
  output logic                        SPEAKER_RIGHT_POWER_BIT,
  output logic                        IRQ
);
  import out_drv_pkg::*;

  reg8_t       page_select_r;
  reg8_t       amp_fault_control_r;
  reg8_t       hp_ctrl_r;
  logic [6:0]  spk_ctrl_r;
  logic [1:0]  short_sync_q;
  logic        hp_short;
  logic        spk_short;
  logic [7:0]  aw_addr_r;
  logic        aw_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_held_r;
  logic        wr_fire;
  logic        wr_hit;
  logic        wr_ok;
  logic        rd_ok;
  reg8_t       rd_value;
  logic        hp_kill;
  logic        spk_kill;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic        irq_status_we;
  logic        irq_mask_we;

  // decode: which word an 8-bit index maps to; index = byte address / 4
  function automatic logic [7:0] word_index(input logic [7:0] addr);
    word_index = {2'h0, addr[7:2]};
  endfunction : word_index

  // legal register: page select always, others only on the service page
  function automatic logic reg_mapped(input logic [7:0] idx, input reg8_t page);
    logic on_page;
    on_page = (page == `SERVICE_PAGE);
    reg_mapped = (idx == `PAGE_SELECT_IDX) ||
                 (on_page && ((idx >= `RSVD_FIRST_IDX && idx <= `SPEAKER_AMP_IDX) ||
                              idx == `IRQ_STATUS_IDX || idx == `IRQ_MASK_IDX));
  endfunction : reg_mapped

  short_sync #(
    .WIDTH(2)
  ) u_short_sync (
    .CLK  (CLK),
    .RESET(RESET),
    .din  ({SPK_SHORT_DETECT, HP_SHORT_DETECT}),
    .dout (short_sync_q)
  );
  assign hp_short  = short_sync_q[0];
  assign spk_short = short_sync_q[1];

  // headphone short clears left/right power when enabled
  assign hp_kill  = hp_short && amp_fault_control_r[`FAULT_HP_CLR_BIT];
  // speaker short clears speaker power when enabled
  assign spk_kill = spk_short && amp_fault_control_r[`FAULT_SPK_CLR_BIT];

  // write channel: address and data captured independently, either order
  assign S_AXI_AWREADY = !aw_held_r && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held_r && !S_AXI_BVALID;
  assign wr_fire       = aw_held_r && w_held_r && !S_AXI_BVALID;
  assign wr_hit        = wr_fire && w_strb_r[0];

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= word_index(S_AXI_AWADDR);
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_r <= 1'b1;
      w_data_r <= S_AXI_WDATA;
      w_strb_r <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // reserved window accepts nothing; writes there get SLVERR
  assign wr_ok = reg_mapped(aw_addr_r, page_select_r) &&
                 !(aw_addr_r >= `RSVD_FIRST_IDX && aw_addr_r <= `RSVD_LAST_IDX);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // page select takes any byte value
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      page_select_r <= `PAGE_SELECT_RESET;
    end else if (wr_hit && aw_addr_r == `PAGE_SELECT_IDX) begin
      page_select_r <= w_data_r[7:0];
    end
  end

  // upper bits stored only, no effect
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      amp_fault_control_r <= `AMP_FAULT_RESET;
    end else if (wr_hit && wr_ok && aw_addr_r == `AMP_FAULT_CONTROL_IDX) begin
      amp_fault_control_r <= w_data_r[7:0];
    end
  end

  // hp_ctrl_r bit 0 is always written as zero and unused; the status bit is read live
  // power bits, cleared by a protected short
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hp_ctrl_r <= `HEADPHONE_RESET;
    end else begin
      if (wr_hit && wr_ok && aw_addr_r == `HEADPHONE_DRIVER_IDX) begin
        hp_ctrl_r <= {w_data_r[7:1], 1'b0};
      end
      // short clear beats a same-cycle power-up write
      if (hp_kill) begin
        hp_ctrl_r[`HP_LEFT_BIT]  <= 1'b0;
        hp_ctrl_r[`HP_RIGHT_BIT] <= 1'b0;
      end
    end
  end

  // class-D power bit; reserved bits kept as written
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      spk_ctrl_r <= {1'b0, `SPEAKER_RSVD_RESET};
    end else begin
      if (wr_hit && wr_ok && aw_addr_r == `SPEAKER_AMP_IDX) begin
        spk_ctrl_r <= w_data_r[7:1];
      end
      if (spk_kill) begin
        spk_ctrl_r[`SPK_POWER_BIT-1] <= 1'b0;
      end
    end
  end

  assign HEADPHONE_LEFT_DRIVER  = hp_ctrl_r[`HP_LEFT_BIT];
  assign HEADPHONE_RIGHT_DRIVER = hp_ctrl_r[`HP_RIGHT_BIT];
  // common-mode code passed to the analog stage
  assign HP_COMMON_MODE         = hp_ctrl_r[`HP_CM_LSB+1:`HP_CM_LSB];
  // short response only matters with protection enabled
  assign HP_SC_POWER_DOWN       = HP_SC_PROTECT_EN && hp_ctrl_r[`HP_SC_ACTION_BIT];
  assign HP_SC_LIMIT_CURRENT    = HP_SC_PROTECT_EN && !hp_ctrl_r[`HP_SC_ACTION_BIT];
  // mono amp: one power bit feeds both speaker halves
  assign SPEAKER_LEFT_POWER_BIT  = spk_ctrl_r[`SPK_POWER_BIT-1];
  assign SPEAKER_RIGHT_POWER_BIT = spk_ctrl_r[`SPK_POWER_BIT-1];

  // events: live short levels; speaker only while powered
  assign irq_status_we = wr_hit && wr_ok && aw_addr_r == `IRQ_STATUS_IDX;
  assign irq_mask_we   = wr_hit && wr_ok && aw_addr_r == `IRQ_MASK_IDX;

  irq_block #(
    .N(2)
  ) u_irq (
    .CLK       (CLK),
    .RESET     (RESET),
    .event_set ({spk_short && SPEAKER_LEFT_POWER_BIT, hp_short}),
    .clear_mask(irq_status_we ? w_data_r[1:0] : 2'h0),
    .mask_we   (irq_mask_we),
    .mask_wdata(w_data_r[1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (IRQ)
  );

  // read path: one transaction at a time, answer one cycle after acceptance
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_ok = reg_mapped(word_index(S_AXI_ARADDR), page_select_r);

  always_comb begin
    rd_value = `RESERVED_READ_VALUE;
    case (word_index(S_AXI_ARADDR))
      `PAGE_SELECT_IDX:       rd_value = page_select_r;
      `AMP_FAULT_CONTROL_IDX: rd_value = amp_fault_control_r;
      // live headphone short in bit 0
      `HEADPHONE_DRIVER_IDX:  rd_value = {hp_ctrl_r[7:1], hp_short};
      // live, non-sticky speaker short in bit 0
      `SPEAKER_AMP_IDX:       rd_value = {spk_ctrl_r, spk_short};
      `IRQ_STATUS_IDX:        rd_value = {6'h00, irq_status};
      `IRQ_MASK_IDX:          rd_value = {6'h00, irq_mask};
      default:                rd_value = `RESERVED_READ_VALUE;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_ok ? {24'h00_0000, rd_value} : 32'h0000_0000;
      S_AXI_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule : out_drv_regs

// *** out_drv_map.svh ***
// register offsets, field positions, reset values and timing counts for the output driver bank
`ifndef OUT_DRV_MAP_SVH
`define OUT_DRV_MAP_SVH
`define PAGE_SELECT_IDX          8'h00
`define RSVD_FIRST_IDX           8'h01
`define RSVD_LAST_IDX            8'h1D
`define AMP_FAULT_CONTROL_IDX    8'h1E
`define HEADPHONE_DRIVER_IDX     8'h1F
`define SPEAKER_AMP_IDX          8'h20
`define IRQ_STATUS_IDX           8'h3E
`define IRQ_MASK_IDX             8'h3F
`define SERVICE_PAGE             8'h01
`define PAGE_SELECT_RESET        8'h00
`define AMP_FAULT_RESET          8'h00
`define HEADPHONE_RESET          8'h04
`define SPEAKER_RESET            8'h06
`define SPEAKER_RSVD_RESET       6'h03
`define FAULT_SPK_CLR_BIT        1
`define FAULT_HP_CLR_BIT         0
`define HP_LEFT_BIT              7
`define HP_RIGHT_BIT             6
`define HP_RSVD_HI_BIT           5
`define HP_CM_LSB                3
`define HP_RSVD_LO_BIT           2
`define HP_SC_ACTION_BIT         1
`define HP_SC_STATUS_BIT         0
`define SPK_POWER_BIT            7
`define SPK_SC_STATUS_BIT        0
`define IRQ_HP_SC_BIT            0
`define IRQ_SPK_SC_BIT           1
`define RESERVED_READ_VALUE      8'h00
`define SYNC_STAGES              2
`endif

// *** out_drv_pkg.sv ***
// types shared by the output driver register bank
package out_drv_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [1:0] cm_level_t;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_e;
endpackage : out_drv_pkg

// *** short_sync.sv ***
// two-flop synchroniser for a short-circuit detector level
module short_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : short_sync

// *** irq_block.sv ***
// sticky event status with write-one-to-clear and mask gating
module irq_block #(
  parameter int N = 2
) (
  input  wire logic         CLK,
  input  wire logic         RESET,
  input  wire logic [N-1:0] event_set,
  input  wire logic [N-1:0] clear_mask,
  input  wire logic         mask_we,
  input  wire logic [N-1:0] mask_wdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);
  // set wins over a clear in the same cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      status <= '0;
    end else begin
      status <= (status & ~clear_mask) | event_set;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mask <= '0;
    end else if (mask_we) begin
      mask <= mask_wdata;
    end
  end

  assign irq = |(status & mask);
endmodule : irq_block

// *** out_drv_checker.sv ***
// concurrent checks on the output driver bank ports
module out_drv_checker
  import out_drv_pkg::*;
(
  input wire logic      CLK,
  input wire logic      RESET,
  input wire logic      S_AXI_AWVALID,
  input wire logic      S_AXI_AWREADY,
  input wire logic      S_AXI_WVALID,
  input wire logic      S_AXI_WREADY,
  input wire axi_resp_e S_AXI_BRESP,
  input wire logic      S_AXI_BVALID,
  input wire logic      S_AXI_BREADY,
  input wire logic      S_AXI_ARVALID,
  input wire logic      S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire axi_resp_e S_AXI_RRESP,
  input wire logic      S_AXI_RVALID,
  input wire logic      S_AXI_RREADY,
  input wire logic      HP_SC_PROTECT_EN,
  input wire logic      HP_SC_POWER_DOWN,
  input wire logic      HP_SC_LIMIT_CURRENT,
  input wire logic      SPEAKER_LEFT_POWER_BIT,
  input wire logic      SPEAKER_RIGHT_POWER_BIT,
  input wire logic      HEADPHONE_LEFT_DRIVER,
  input wire logic      IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  rd_latency_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer not one cycle after address");
  rd_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped or changed before taken");
  wr_latency_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer not two cycles after address and data");
  wr_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped or changed before taken");
  busy_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while answer pending");
  rsvd_zero_a: assert property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
    else $error("refused read returned nonzero data");
  spk_pair_a: assert property (SPEAKER_LEFT_POWER_BIT == SPEAKER_RIGHT_POWER_BIT)
    else $error("speaker power bits differ");
  sc_mode_a: assert property (HP_SC_PROTECT_EN |-> HP_SC_POWER_DOWN != HP_SC_LIMIT_CURRENT)
    else $error("short response not exactly one action");
  sc_off_a: assert property (!HP_SC_PROTECT_EN |-> !HP_SC_POWER_DOWN && !HP_SC_LIMIT_CURRENT)
    else $error("short response active while protection off");
  hp_on_write_a: assert property ($rose(HEADPHONE_LEFT_DRIVER) |-> S_AXI_BVALID)
    else $error("headphone left powered up without a write");
  spk_on_write_a: assert property ($rose(SPEAKER_LEFT_POWER_BIT) |-> S_AXI_BVALID)
    else $error("speaker powered up without a write");
  rd_done_c: cover property (S_AXI_RVALID && S_AXI_RREADY);
  irq_up_c: cover property ($rose(IRQ));
  rd_err_c: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
  spk_drop_c: cover property ($fell(SPEAKER_LEFT_POWER_BIT));
endmodule : out_drv_checker

// *** analog_stage_model.sv ***
// behavioural analog driver stages feeding the short detectors
module analog_stage_model (
  input  wire logic hp_left,
  input  wire logic hp_right,
  input  wire logic spk_power,
  input  wire logic hp_short_cmd,
  input  wire logic spk_short_cmd,
  output logic      hp_detect,
  output logic      spk_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  // short seen only on running driver
  assign hp_detect = hp_short_cmd && (hp_left || hp_right);
  assign spk_detect = spk_short_cmd && spk_power;
endmodule : analog_stage_model

// *** output_driver_power_fault_regs_tb.sv ***
// self-checking bench for the output driver register bank
module output_driver_power_fault_regs_tb;
  import out_drv_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK, RESET, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
  axi_resp_e   S_AXI_BRESP, S_AXI_RRESP;
  cm_level_t   HP_COMMON_MODE;
  logic        HP_SHORT_DETECT, SPK_SHORT_DETECT, HP_SC_PROTECT_EN, HEADPHONE_LEFT_DRIVER;
  logic        HEADPHONE_RIGHT_DRIVER, HP_SC_POWER_DOWN, HP_SC_LIMIT_CURRENT;
  logic        SPEAKER_LEFT_POWER_BIT, SPEAKER_RIGHT_POWER_BIT, hp_short_cmd, spk_short_cmd;
  int          failures, checks, cycles;
  out_drv_regs u_out_drv_regs (.*);
  analog_stage_model u_analog_stage_model (.hp_left(HEADPHONE_LEFT_DRIVER), .hp_right(HEADPHONE_RIGHT_DRIVER),
    .spk_power(SPEAKER_LEFT_POWER_BIT), .hp_short_cmd(hp_short_cmd), .spk_short_cmd(spk_short_cmd),
    .hp_detect(HP_SHORT_DETECT), .spk_detect(SPK_SHORT_DETECT));
  always #20 CLK = ~CLK;
  function automatic logic [5:0] hp_out(input logic [7:0] d, input logic pe);
    return {d[7], d[6], d[4:3], pe & d[1], pe & ~d[1]};
  endfunction : hp_out
  task automatic close_out();
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bus tasks start just after an edge; handshakes read at the falling edge, which the next rise matches
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input axi_resp_e er);
    logic aw, w, ta, tw;
    axi_resp_e r;
    aw = 0;
    w = 0;
    S_AXI_AWADDR <= {idx, 2'h0};
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(aw && w)) begin
      @(negedge CLK);
      ta = S_AXI_AWVALID && S_AXI_AWREADY;
      tw = S_AXI_WVALID && S_AXI_WREADY;
      @(posedge CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      aw |= ta;
      w |= tw;
    end
    ta = 0;
    while (!ta) begin
      @(negedge CLK);
      ta = S_AXI_BVALID;
      r = S_AXI_BRESP;
      @(posedge CLK);
    end
    chk(r, er);
  endtask : wr
  task automatic rd(input logic [5:0] idx, input logic [7:0] ed, input axi_resp_e er);
    logic t;
    logic [31:0] dv;
    axi_resp_e r;
    t = 0;
    S_AXI_ARADDR <= {idx, 2'h0};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (!t) begin
      @(negedge CLK);
      t = S_AXI_ARVALID && S_AXI_ARREADY;
      @(posedge CLK);
    end
    S_AXI_ARVALID <= 1'b0;
    t = 0;
    while (!t) begin
      @(negedge CLK);
      t = S_AXI_RVALID;
      dv = S_AXI_RDATA;
      r = S_AXI_RRESP;
      @(posedge CLK);
    end
    chk(dv, {24'h0, ed});
    chk(r, er);
  endtask : rd
  // the whole run needs well under a thousand cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    logic [7:0] d, p;
    int i;
    CLK = 0;
    RESET = 1;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    {HP_SC_PROTECT_EN, hp_short_cmd, spk_short_cmd} = '0;
    void'($urandom(32'hA2E6));
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    chk({HEADPHONE_LEFT_DRIVER, HEADPHONE_RIGHT_DRIVER, SPEAKER_LEFT_POWER_BIT, HP_COMMON_MODE}, 0);
    rd(6'h00, 8'h00, RESP_OKAY);
    wr(6'h1F, 8'hC4, RESP_SLVERR);
    rd(6'h1F, 8'h00, RESP_SLVERR);
    wr(6'h00, 8'h01, RESP_OKAY);
    rd(6'h1E, 8'h00, RESP_OKAY);
    rd(6'h1F, 8'h04, RESP_OKAY);
    rd(6'h20, 8'h06, RESP_OKAY);
    for (i = 0; i < 6; i++) begin
      d = 8'($urandom_range(29, 1));
      wr(d[5:0], 8'($urandom), RESP_SLVERR);
      rd(d[5:0], 8'h00, RESP_OKAY);
      rd(6'($urandom_range(61, 33)), 8'h00, RESP_SLVERR);
    end
    for (i = 0; i < 12; i++) begin
      d = {2'($urandom), 1'b0, 2'(i), 1'b1, 1'($urandom), 1'b0};
      p = {6'($urandom), 2'h0};
      HP_SC_PROTECT_EN <= 1'($urandom);
      wr(6'h1F, d, RESP_OKAY);
      wr(6'h1E, p, RESP_OKAY);
      rd(6'h1E, p, RESP_OKAY);
      rd(6'h1F, d, RESP_OKAY);
      chk({HEADPHONE_LEFT_DRIVER, HEADPHONE_RIGHT_DRIVER, HP_COMMON_MODE, HP_SC_POWER_DOWN, HP_SC_LIMIT_CURRENT},
          hp_out(d, HP_SC_PROTECT_EN));
    end
    wr(6'h1E, 8'h00, RESP_OKAY);
    wr(6'h1F, 8'hC4, RESP_OKAY);
    wr(6'h20, 8'h86, RESP_OKAY);
    hp_short_cmd <= 1'b1;
    spk_short_cmd <= 1'b1;
    repeat (4) @(posedge CLK);
    rd(6'h1F, 8'hC5, RESP_OKAY);
    rd(6'h20, 8'h87, RESP_OKAY);
    wr(6'h1E, 8'h01, RESP_OKAY);
    repeat (4) @(posedge CLK);
    chk({HEADPHONE_LEFT_DRIVER, HEADPHONE_RIGHT_DRIVER, SPEAKER_LEFT_POWER_BIT, SPEAKER_RIGHT_POWER_BIT}, 4'h3);
    wr(6'h1E, 8'h03, RESP_OKAY);
    repeat (4) @(posedge CLK);
    rd(6'h20, 8'h06, RESP_OKAY);
    hp_short_cmd <= 1'b0;
    // synced short is already low with both headphone drivers off; two idle cycles before the power-up write
    repeat (2) @(posedge CLK);
    wr(6'h1F, 8'hC4, RESP_OKAY);
    hp_short_cmd <= 1'b1;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk(HEADPHONE_LEFT_DRIVER, 1);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk({HEADPHONE_LEFT_DRIVER, HEADPHONE_RIGHT_DRIVER}, 0);
    @(posedge CLK);
    // both shorts were seen earlier: sticky status, gated by mask
    chk(IRQ, 0);
    rd(6'h3E, 8'h03, RESP_OKAY);
    wr(6'h3F, 8'h01, RESP_OKAY);
    chk(IRQ, 1);
    wr(6'h3E, 8'h03, RESP_OKAY);
    chk(IRQ, 0);
    rd(6'h3E, 8'h00, RESP_OKAY);
    p = 8'($urandom);
    if (p == 8'h01) p = 8'h02;
    wr(6'h00, p, RESP_OKAY);
    rd(6'h00, p, RESP_OKAY);
    // low byte lane off: write answered but ignored
    S_AXI_WSTRB <= 4'hE;
    wr(6'h00, 8'h01, RESP_OKAY);
    S_AXI_WSTRB <= 4'hF;
    rd(6'h00, p, RESP_OKAY);
    rd(6'h20, 8'h00, RESP_SLVERR);
    wr(6'h00, 8'hFF, RESP_OKAY);
    rd(6'h00, 8'hFF, RESP_OKAY);
    close_out();
  end
endmodule : output_driver_power_fault_regs_tb
bind out_drv_regs out_drv_checker u_out_drv_checker (.*);
